//--- bench/pmst_host_model.sv
// Host model: issues committed writes and read starts, takes answers.
// Assumes framing on the serial link is already resolved upstream.
`timescale 1ns/1ps
`default_nettype none
module pmst_host_model (
    input  wire logic                core_clk,
    input  wire pmst_pkg::pmst_rsp_t rsp,
    output var  pmst_pkg::pmst_wr_t  wr,
    output var  pmst_pkg::pmst_rd_t  rd
);
    initial begin
        wr = '0;
        rd = '0;
    end

    task automatic write_cmd(input logic [7:0] code, input logic [7:0] data);
        @(posedge core_clk);
        wr <= '{valid: 1'b1, code: code, data: data};
        @(posedge core_clk);
        wr <= '0;
    endtask : write_cmd

    // Answer stands one cycle after the taking edge
    task automatic read_cmd(input logic [7:0] code, output pmst_pkg::pmst_rsp_t ans);
        @(posedge core_clk);
        rd <= '{req: 1'b1, code: code};
        @(posedge core_clk);
        rd <= '0;
        @(posedge core_clk);
        ans = rsp;
    endtask : read_cmd
endmodule : pmst_host_model
`default_nettype wire

//--- bench/pmst_regs_monitor.sv
// Port-level assertions for the vendor status byte, read answers and invalid writes.
// Bound into every pmst_regs instance; sees that module's ports only.
`timescale 1ns/1ps
`default_nettype none
module pmst_regs_monitor #(
    parameter int REFRESH_1MS_CYC = 20
) (
    input wire logic                core_clk,
    input wire logic                rst_b,
    input wire pmst_pkg::pmst_wr_t  wr,
    input wire pmst_pkg::pmst_rd_t  rd,
    input wire pmst_pkg::pmst_rsp_t rsp,
    input wire logic                por_check_fail,
    input wire logic                self_check_busy,
    input wire logic                follower_pending,
    input wire logic                output_voltage_reset_event,
    input wire logic                back_channel_fault,
    input wire logic                sync_fault,
    input wire logic [7:0]          alert_mask_vendor,
    input wire logic [7:0]          vendor_status_q,
    input wire logic                vendor_alert_q,
    input wire logic                cml_ivc_set_q,
    input wire logic                status_byte_cml_set_q,
    input wire logic                host_notify_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    chk_read_answer: assert property (rd.req && !$past(rd.req) |=> rsp.ack)
        else $error("read start not answered");
    chk_unused_zero: assert property ((vendor_status_q & 8'h31) == 8'h00)
        else $error("unsupported status bit set");
    chk_por_latch: assert property (por_check_fail |=> vendor_status_q[7])
        else $error("power-on fault not latched");
    chk_self_live: assert property ($past(rst_b) |->
        vendor_status_q[6] == $past(self_check_busy || follower_pending))
        else $error("self-check bit not live");
    chk_w1c_clear: assert property (wr.valid && wr.code == 8'h80 && wr.data[1] && !sync_fault
        |=> !vendor_status_q[1])
        else $error("write one did not clear");
    chk_clear_all: assert property (wr.valid && wr.code == 8'h03 && !(por_check_fail
        || output_voltage_reset_event || back_channel_fault || sync_fault)
        |=> (vendor_status_q & 8'h8e) == 8'h00)
        else $error("clear faults left a bit");
    chk_mask_all: assert property ($past(alert_mask_vendor) == 8'hff |-> !vendor_alert_q)
        else $error("masked alert raised");
    chk_ivc_pulse: assert property (wr.valid && wr.code inside {8'h88, 8'h8b, 8'h8c, 8'h8d}
        |=> cml_ivc_set_q && status_byte_cml_set_q && host_notify_q)
        else $error("read-only write not flagged");

    cover property (rsp.ack && rsp.served);
    cover property (vendor_alert_q);
    cover property (host_notify_q);
endmodule : pmst_regs_monitor

bind pmst_regs pmst_regs_monitor #(.REFRESH_1MS_CYC(REFRESH_1MS_CYC)) mon_u (.*);
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the vendor status byte and telemetry words.
// Assumes the host model issues commands; 1 ms refresh period cut to 20.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                core_clk, rst_b;
    pmst_pkg::pmst_wr_t  wr;
    pmst_pkg::pmst_rd_t  rd;
    pmst_pkg::pmst_rsp_t rsp, r;
    logic [7:0]          phase_sel, alert_mask_vendor, vendor_status_q;
    logic                follower_mode, por_check_fail, self_check_busy, follower_pending;
    logic                output_voltage_reset_event, back_channel_fault, sync_fault;
    pmst_pkg::pmst_lin_t vin_controller, vin_phase, iout_total, iout_phase, temp_max, temp_phase;
    logic [15:0]         vout_scaled, vout_sense_raw;
    logic                vendor_alert_q, cml_ivc_set_q, status_byte_cml_set_q, host_notify_q;
    int                  mismatches = 0;
    int                  comparisons = 0;
    int                  stat = 0;
    int                  evs [4] = '{7, 3, 2, 1};
    logic [7:0]          codes [4] = '{8'h88, 8'h8b, 8'h8c, 8'h8d};
    logic [15:0]         want [$];
    logic [31:0]         seed = 32'h00001f2d;

    pmst_regs #(.REFRESH_1MS_CYC(20)) dut_u (.*);
    pmst_host_model host_u (.core_clk(core_clk), .rsp(rsp), .wr(wr), .rd(rd));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // One-cycle event pulse on the source feeding status bit b
    task automatic ev(input int b);
        @(posedge core_clk);
        case (b)
            7: por_check_fail <= 1'b1;
            3: output_voltage_reset_event <= 1'b1;
            2: back_channel_fault <= 1'b1;
            default: sync_fault <= 1'b1;
        endcase
        @(posedge core_clk);
        {por_check_fail, output_voltage_reset_event, back_channel_fault, sync_fault} <= '0;
        stat |= 1 << b;
    endtask : ev

    task automatic rd_stat(input logic [7:0] live);
        host_u.read_cmd(8'h80, r);
        chk("status read", r.data, 16'(stat) | 16'(live));
        chk("status answer", 16'({r.ack, r.served}), 16'h0003);
        chk("status port", 16'(vendor_status_q), 16'(stat) | 16'(live));
    endtask : rd_stat

    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        {phase_sel, alert_mask_vendor, follower_mode, por_check_fail, self_check_busy} = '0;
        {follower_pending, output_voltage_reset_event, back_channel_fault, sync_fault} = '0;
        {vin_controller, vin_phase, iout_total, iout_phase, temp_max, temp_phase} = '0;
        {vout_scaled, vout_sense_raw} = '0;
        rst_b = 1'b0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_stat(8'h00);
        foreach (evs[i]) ev(evs[i]);
        rd_stat(8'h00);
        host_u.write_cmd(8'h80, 8'h71);
        rd_stat(8'h00);
        foreach (evs[i]) begin
            host_u.write_cmd(8'h80, 8'(1 << evs[i]));
            stat &= ~(1 << evs[i]);
            rd_stat(8'h00);
        end
        foreach (evs[i]) ev(evs[i]);
        @(posedge core_clk);
        chk("alert", 16'(vendor_alert_q), 16'h0001);
        alert_mask_vendor <= 8'hff;
        repeat (2) @(posedge core_clk);
        chk("masked alert", 16'(vendor_alert_q), 16'h0000);
        host_u.write_cmd(8'h03, 8'h00);
        stat = 0;
        rd_stat(8'h00);
        self_check_busy <= 1'b1;
        rd_stat(8'h40);
        self_check_busy <= 1'b0;
        follower_pending <= 1'b1;
        rd_stat(8'h40);
        follower_pending <= 1'b0;
        rd_stat(8'h00);
        $display("status tests done");
        for (int k = 0; k < 4; k++) begin
            phase_sel <= k[0] ? 8'hff : 8'(xs()) & 8'h7f;
            follower_mode <= k[1];
            {vin_controller, vin_phase, iout_total, iout_phase} <= {xs(), xs()};
            {temp_max, temp_phase, vout_scaled, vout_sense_raw} <= {xs(), xs()};
            repeat (3010) @(posedge core_clk);
            want = '{phase_sel == 8'hff ? vin_controller : vin_phase,
                     follower_mode ? vout_sense_raw : vout_scaled,
                     phase_sel == 8'hff ? iout_total : iout_phase,
                     phase_sel == 8'hff ? temp_max : temp_phase};
            foreach (want[i]) begin
                host_u.read_cmd(codes[i], r);
                chk("telemetry", r.data, want[i]);
            end
            chk("exponent", 16'(r.data[15:11]), 16'(want[3][15:11]));
        end
        $display("telemetry tests done");
        foreach (codes[i]) begin
            host_u.write_cmd(codes[i], 8'(xs()));
            @(posedge core_clk);
            chk("invalid cmd", 16'({cml_ivc_set_q, status_byte_cml_set_q, host_notify_q}),
                16'h0007);
        end
        host_u.read_cmd(8'h99, r);
        chk("unknown code", r.data | 16'(r.served), 16'h0000);
        $display("write and refusal tests done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire

//--- rtl/pmst_pkg.sv
// Constants and carriers for the vendor status and telemetry registers.
// Assumes a 10 MHz core clock and a command decoder outside this block.
package pmst_pkg;

    // Command codes served here
    localparam logic [7:0] PMST_CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] PMST_CMD_VENDOR_STAT  = 8'h80;
    localparam logic [7:0] PMST_CMD_IN_VOLT      = 8'h88;
    localparam logic [7:0] PMST_CMD_OUT_VOLT     = 8'h8b;
    localparam logic [7:0] PMST_CMD_OUT_CURR     = 8'h8c;
    localparam logic [7:0] PMST_CMD_TEMP         = 8'h8d;

    // Phase selector value meaning the whole stack
    localparam logic [7:0] PMST_PHASE_ALL = 8'hff;

    // Vendor status bit positions
    localparam int PMST_BIT_POR_FAULT  = 7;
    localparam int PMST_BIT_SELF_CHECK = 6;
    localparam int PMST_BIT_VOUT_RESET = 3;
    localparam int PMST_BIT_BACK_CHAN  = 2;
    localparam int PMST_BIT_SYNC_FAULT = 1;

    // Latched, write-one-to-clear bits: 7, 3, 2, 1
    localparam logic [7:0] PMST_W1C_MASK    = 8'h8e;
    localparam logic [7:0] PMST_STAT_RESET  = 8'h00;
    localparam logic [15:0] PMST_WORD_RESET = 16'h0000;

    // Linear word layout
    localparam int PMST_EXP_MSB = 15;
    localparam int PMST_EXP_LSB = 11;
    localparam int PMST_MAN_MSB = 10;
    localparam int PMST_MAN_LSB = 0;

    // Refresh timing
    localparam int PMST_CLK_KHZ         = 10000;
    localparam int PMST_REFRESH_1MS_US  = 1000;
    localparam int PMST_REFRESH_TEMP_US = 300;
    localparam int PMST_REFRESH_1MS_CYC  = PMST_REFRESH_1MS_US * PMST_CLK_KHZ / 1000;
    localparam int PMST_REFRESH_TEMP_CYC = PMST_REFRESH_TEMP_US * PMST_CLK_KHZ / 1000;

    // Linear format value: exponent and mantissa, both two's complement
    typedef struct packed {
        logic [4:0]  exp;
        logic [10:0] man;
    } pmst_lin_t;

    // Committed write transaction from the command decoder
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic [7:0] data;
    } pmst_wr_t;

    // Start of a read transaction
    typedef struct packed {
        logic       req;
        logic [7:0] code;
    } pmst_rd_t;

    // Read answer
    typedef struct packed {
        logic        ack;
        logic        served;
        logic [15:0] data;
    } pmst_rsp_t;

    typedef enum logic [1:0] {
        PMST_ST_IDLE = 2'b01,
        PMST_ST_BUSY = 2'b10
    } pmst_state_t;

endpackage : pmst_pkg

//--- rtl/pmst_regs.sv
// Vendor status byte and telemetry words behind the management-bus commands.
// Assumes a command decoder on core_clk delivering read starts and writes.
//
// Functional notes
// - Bit 7 latches on invalid trim, checksum or pin detection result.
// - Bit 6 is live: high while self-check runs or followers silent.
// - Bit 3 latches on an output-voltage reset event until cleared.
// - Bit 2 latches on a back-channel fault until cleared.
// - Bit 1 latches on a synchronization fault until cleared.
// - Writing one clears a set latched bit; writing zero leaves it.
// - Each alerting status bit has a mask bit gating its alert.
// - Clear-faults command clears all latched vendor status bits too.
// - Input voltage at 88h, read word only, refreshed each millisecond.
// - Linear words: exponent in bits 15:11, mantissa in 10:0.
// - Writing a telemetry command flags invalid command and notifies host.
// - Phase all-ones gives controller input voltage, else selected phase.
// - Output voltage at 8Bh, unsigned word, refreshed each millisecond.
// - Loop follower reports raw sense voltage, ignoring output scaling.
// - Output current at 8Ch, linear word, refreshed each millisecond.
// - Phase all-ones gives summed stack current, else selected phase.
// - Temperature at 8Dh, hottest stage if phase all-ones, else selected phase, refreshed every 300 us.
`timescale 1ns/1ps
`default_nettype none
module pmst_regs #(
    parameter int REFRESH_1MS_CYC = pmst_pkg::PMST_REFRESH_1MS_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire pmst_pkg::pmst_wr_t  wr,
    input  wire pmst_pkg::pmst_rd_t  rd,
    output var  pmst_pkg::pmst_rsp_t rsp,
    input  wire logic [7:0]          phase_sel,
    input  wire logic                follower_mode,
    input  wire logic                por_check_fail,
    input  wire logic                self_check_busy,
    input  wire logic                follower_pending,
    input  wire logic                output_voltage_reset_event,
    input  wire logic                back_channel_fault,
    input  wire logic                sync_fault,
    input  wire logic [7:0]          alert_mask_vendor,
    input  wire pmst_pkg::pmst_lin_t vin_controller,
    input  wire pmst_pkg::pmst_lin_t vin_phase,
    input  wire logic [15:0]         vout_scaled,
    input  wire logic [15:0]         vout_sense_raw,
    input  wire pmst_pkg::pmst_lin_t iout_total,
    input  wire pmst_pkg::pmst_lin_t iout_phase,
    input  wire pmst_pkg::pmst_lin_t temp_max,
    input  wire pmst_pkg::pmst_lin_t temp_phase,
    output var  logic [7:0]          vendor_status_q,
    output var  logic                vendor_alert_q,
    output var  logic                cml_ivc_set_q,
    output var  logic                status_byte_cml_set_q,
    output var  logic                host_notify_q
);

    // ---------------- Telemetry sources and refresh ----------------
    logic        phase_all;
    logic [15:0] vin_src;
    logic [15:0] vout_src;
    logic [15:0] iout_src;
    logic [15:0] temp_src;
    logic [15:0] vin_held;
    logic [15:0] vout_held;
    logic [15:0] iout_held;
    logic [15:0] temp_held;

    always_comb begin
        phase_all = (phase_sel == pmst_pkg::PMST_PHASE_ALL);
        vin_src   = phase_all ? vin_controller : vin_phase;
        iout_src  = phase_all ? iout_total : iout_phase;
        temp_src  = phase_all ? temp_max : temp_phase;
        vout_src  = follower_mode ? vout_sense_raw : vout_scaled;
    end

    pmst_telem_chan #(
        .PERIOD (REFRESH_1MS_CYC)
    ) u_vin (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .src_word (vin_src),
        .held_q   (vin_held)
    );

    pmst_telem_chan #(
        .PERIOD (REFRESH_1MS_CYC)
    ) u_vout (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .src_word (vout_src),
        .held_q   (vout_held)
    );

    pmst_telem_chan #(
        .PERIOD (REFRESH_1MS_CYC)
    ) u_iout (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .src_word (iout_src),
        .held_q   (iout_held)
    );

    pmst_telem_chan #(
        .PERIOD (pmst_pkg::PMST_REFRESH_TEMP_CYC)
    ) u_temp (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .src_word (temp_src),
        .held_q   (temp_held)
    );

    // ---------------- Vendor status byte ----------------
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [7:0] stat_set;
    logic [7:0] stat_clr;
    logic [7:0] stat_view;
    logic [7:0] view_d;
    logic       alert_d;
    logic       live_busy;

    always_comb begin
        stat_set = 8'h00;
        stat_set[pmst_pkg::PMST_BIT_POR_FAULT]  = por_check_fail;
        stat_set[pmst_pkg::PMST_BIT_VOUT_RESET] = output_voltage_reset_event;
        stat_set[pmst_pkg::PMST_BIT_BACK_CHAN]  = back_channel_fault;
        stat_set[pmst_pkg::PMST_BIT_SYNC_FAULT] = sync_fault;
        stat_clr = 8'h00;
        if (wr.valid && wr.code == pmst_pkg::PMST_CMD_VENDOR_STAT) begin
            stat_clr = wr.data & pmst_pkg::PMST_W1C_MASK;
        end
        if (wr.valid && wr.code == pmst_pkg::PMST_CMD_CLEAR_FAULTS) begin
            stat_clr = pmst_pkg::PMST_W1C_MASK;
        end
        // Set wins over a clear in the same cycle
        stat_d = ((stat_q & ~stat_clr) | stat_set) & pmst_pkg::PMST_W1C_MASK;
        live_busy = self_check_busy | follower_pending;
        view_d = stat_d;
        view_d[pmst_pkg::PMST_BIT_SELF_CHECK] = live_busy;
        stat_view = stat_q;
        stat_view[pmst_pkg::PMST_BIT_SELF_CHECK] = live_busy;
        // Only latched bits raise the alert, each gated by its mask bit
        alert_d = |(stat_d & ~alert_mask_vendor);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q          <= pmst_pkg::PMST_STAT_RESET;
            vendor_status_q <= pmst_pkg::PMST_STAT_RESET;
            vendor_alert_q  <= 1'b0;
        end else begin
            stat_q          <= stat_d;
            vendor_status_q <= view_d;
            vendor_alert_q  <= alert_d;
        end
    end

    // ---------------- Read answer and invalid writes ----------------
    pmst_pkg::pmst_state_t state_q;
    pmst_pkg::pmst_state_t state_d;
    pmst_pkg::pmst_rsp_t   rsp_d;
    logic                  ro_write;
    logic                  ivc_d;

    always_comb begin
        state_d = state_q;
        rsp_d   = rsp;
        rsp_d.ack = 1'b0;
        case (state_q)
            pmst_pkg::PMST_ST_IDLE: begin
                if (rd.req) begin
                    // Whole word captured at once from the held values
                    rsp_d.ack    = 1'b1;
                    rsp_d.served = 1'b1;
                    case (rd.code)
                        pmst_pkg::PMST_CMD_VENDOR_STAT: rsp_d.data = {8'h00, stat_view};
                        pmst_pkg::PMST_CMD_IN_VOLT:     rsp_d.data = vin_held;
                        pmst_pkg::PMST_CMD_OUT_VOLT:    rsp_d.data = vout_held;
                        pmst_pkg::PMST_CMD_OUT_CURR:    rsp_d.data = iout_held;
                        pmst_pkg::PMST_CMD_TEMP:        rsp_d.data = temp_held;
                        default: begin
                            rsp_d.served = 1'b0;
                            rsp_d.data   = pmst_pkg::PMST_WORD_RESET;
                        end
                    endcase
                    state_d = pmst_pkg::PMST_ST_BUSY;
                end
            end
            pmst_pkg::PMST_ST_BUSY: begin
                // Snapshot stands until the next read start
                state_d = pmst_pkg::PMST_ST_IDLE;
            end
            default: begin
                state_d = pmst_pkg::PMST_ST_IDLE;
            end
        endcase

        ro_write = 1'b0;
        if (wr.valid) begin
            case (wr.code)
                pmst_pkg::PMST_CMD_IN_VOLT,
                pmst_pkg::PMST_CMD_OUT_VOLT,
                pmst_pkg::PMST_CMD_OUT_CURR,
                pmst_pkg::PMST_CMD_TEMP: ro_write = 1'b1;
                default: ro_write = 1'b0;
            endcase
        end
        ivc_d = ro_write;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q               <= pmst_pkg::PMST_ST_IDLE;
            rsp                   <= '0;
            cml_ivc_set_q         <= 1'b0;
            status_byte_cml_set_q <= 1'b0;
            host_notify_q         <= 1'b0;
        end else begin
            state_q               <= state_d;
            rsp                   <= rsp_d;
            cml_ivc_set_q         <= ivc_d;
            status_byte_cml_set_q <= ivc_d;
            host_notify_q         <= ivc_d;
        end
    end

endmodule : pmst_regs
`default_nettype wire

//--- rtl/pmst_telem_chan.sv
// One telemetry channel: holds a 16-bit word refreshed at a fixed period.
// Assumes the source word is produced on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pmst_telem_chan #(
    parameter int PERIOD = 1000
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] src_word,
    output var  logic [15:0] held_q
);

    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] div_q;
    logic [CW-1:0] div_d;
    logic [15:0]   held_d;
    logic          tick;

    // Divider gives one enable pulse per refresh period
    always_comb begin
        tick   = (div_q == LAST);
        div_d  = tick ? '0 : div_q + CW'(1);
        held_d = tick ? src_word : held_q;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q  <= '0;
            held_q <= pmst_pkg::PMST_WORD_RESET;
        end else begin
            div_q  <= div_d;
            held_q <= held_d;
        end
    end

endmodule : pmst_telem_chan
`default_nettype wire
